// ===== design/twc_pkg.sv
// Constants, field layouts and calendar helper functions for the three-wire calendar
package twc_pkg;

  // ********************
  // Register map
  // ********************
  localparam int         NUM_REGS   = 8;
  localparam logic [2:0] ADDR_SEC   = 3'h0;
  localparam logic [2:0] ADDR_MIN   = 3'h1;
  localparam logic [2:0] ADDR_HOUR  = 3'h2;
  localparam logic [2:0] ADDR_DATE  = 3'h3;
  localparam logic [2:0] ADDR_MONTH = 3'h4;
  localparam logic [2:0] ADDR_WDAY  = 3'h5;
  localparam logic [2:0] ADDR_YEAR  = 3'h6;
  localparam logic [2:0] ADDR_GUARD = 3'h7;
  localparam logic [2:0] ADDR_LAST  = 3'h7;

  // ********************
  // Field positions
  // ********************
  localparam int HALT_BIT   = 7;
  localparam int MODE12_BIT = 7;
  localparam int PM_BIT     = 5;
  localparam int GUARD_BIT  = 7;
  localparam int DIR_BIT    = 0;

  // Writable bits per register, byte n belongs to address n
  localparam logic [63:0] FIELD_MASK  = 64'h80ff071f3fbf7fff;
  // Reset image: halted, 00:00:00, 01-01-00, weekday 1, write-guarded
  localparam logic [63:0] RESET_IMAGE = 64'h8000010101000080;

  // ********************
  // Command byte
  // ********************
  localparam logic [6:0] CMD_BURST_HI  = 7'h5f;
  localparam logic [3:0] CMD_SINGLE_HI = 4'h8;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // ********************
  // BCD limits
  // ********************
  localparam logic [6:0] SEC_LAST   = 7'h59;
  localparam logic [6:0] MIN_LAST   = 7'h59;
  localparam logic [4:0] HR12_LAST  = 5'h12;
  localparam logic [4:0] HR12_PRE   = 5'h11;
  localparam logic [4:0] HR12_FIRST = 5'h01;
  localparam logic [5:0] HR24_LAST  = 6'h23;
  localparam logic [7:0] MON_LAST   = 8'h12;
  localparam logic [7:0] YEAR_LAST  = 8'h99;
  localparam logic [2:0] WDAY_LAST  = 3'h7;
  localparam logic [7:0] BCD_ONE    = 8'h01;

  // ********************
  // Timing
  // ********************
  localparam int OSC_FREQ_HZ          = 32768;
  localparam int SECOND_S             = 1;
  localparam int OSC_CYCLES_PER_SEC_D = OSC_FREQ_HZ * SECOND_S;

  // ********************
  // Helpers
  // ********************
  function automatic logic [7:0] twc_bcd_inc(input logic [7:0] v);
    twc_bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic twc_is_leap(input logic [7:0] y);
    twc_is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                       : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] twc_month_len(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:                      twc_month_len = twc_is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: twc_month_len = 8'h30;
      default:                    twc_month_len = 8'h31;
    endcase
  endfunction

endpackage

// ===== design/twc_calendar.sv
// Three-wire BCD calendar: serial link, register file and timekeeping
`timescale 1ns/10ps

module twc_calendar #(
  parameter int OSC_CYCLES_PER_SEC = twc_pkg::OSC_CYCLES_PER_SEC_D
) (
  // System
  input  wire logic mclk,
  input  wire logic resetn,
  // Serial link
  input  wire logic shift_clk,
  input  wire logic transfer_enable_line,
  input  wire logic bidir_data_line_in,
  output logic      bidir_data_line_out,
  output logic      bidir_data_line_oe,
  // Crystal
  input  wire logic crystal_in_pin,
  output logic      crystal_out_pin
);
  import twc_pkg::*;

  localparam int PRESC_W = $clog2(OSC_CYCLES_PER_SEC);

  // Prescaler needs at least two crystal periods per second
  if (OSC_CYCLES_PER_SEC < 2) begin : g_osc_check
    $error("OSC_CYCLES_PER_SEC must be at least 2");
  end

  function automatic logic [2:0] sel_addr(input logic burst, input logic [2:0] idx,
                                          input logic [7:0] cmd);
    sel_addr = burst ? idx : cmd[3:1];
  endfunction

  // ************************************
  // Register file and snapshot (mclk)
  // ************************************
  logic [7:0]         cal_r [NUM_REGS];
  logic [7:0]         cal_nxt [NUM_REGS];
  logic [7:0]         snap_r [NUM_REGS];
  logic               te_s1_r;
  logic               te_s2_r;
  logic               xi_s1_r;
  logic               xi_s2_r;
  logic               xi_s3_r;
  logic               wt_s1_r;
  logic               wt_s2_r;
  logic               wt_s3_r;
  logic [PRESC_W-1:0] presc_r;
  logic               osc_out_r;

  // ************************************
  // Link side (shift_clk)
  // ************************************
  logic       link_rst_n;
  logic [2:0] cnt_r;
  logic       cmd_done_r;
  logic [7:0] cmd_r;
  logic [7:0] sh_r;
  logic [2:0] wbit_r;
  logic [2:0] wbyte_r;
  logic       wdone_r;
  logic       wr_tgl_r;
  logic [2:0] wr_addr_r;
  logic [7:0] wr_data_r;
  logic       wr_burst_r;
  logic       oe_r;
  logic       dout_r;
  logic [2:0] rbit_r;
  logic [2:0] rbyte_r;
  logic       rdone_r;

  // ************************************
  // Command decode
  // ************************************
  logic       is_read;
  logic       is_burst;
  logic       xfer_ok;
  logic       wr_phase;
  logic       rd_phase;
  logic       byte_end;
  logic [7:0] sh_nxt;
  logic [2:0] waddr;
  logic [2:0] raddr;
  logic [7:0] rd_byte;

  assign link_rst_n = transfer_enable_line & resetn;
  assign is_read    = cmd_r[DIR_BIT];
  assign is_burst   = (cmd_r[7:1] == CMD_BURST_HI);
  // Test pattern and malformed commands match neither form and do nothing
  assign xfer_ok    = is_burst | (cmd_r[7:4] == CMD_SINGLE_HI);
  assign wr_phase   = cmd_done_r & xfer_ok & ~is_read & ~wdone_r;
  assign rd_phase   = cmd_done_r & xfer_ok & is_read & ~rdone_r;
  assign sh_nxt     = {bidir_data_line_in, sh_r[7:1]};
  assign byte_end   = wr_phase & (wbit_r == BIT_LAST);
  assign waddr      = sel_addr(is_burst, wbyte_r, cmd_r);
  assign raddr      = sel_addr(is_burst, rbyte_r, cmd_r);
  assign rd_byte    = snap_r[raddr];

  // ************************************
  // Rising edge: command and write data
  // ************************************
  always_ff @(posedge shift_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cnt_r      <= 3'h0;
      cmd_done_r <= 1'b0;
      cmd_r      <= 8'h00;
      sh_r       <= 8'h00;
      wbit_r     <= 3'h0;
      wbyte_r    <= 3'h0;
      wdone_r    <= 1'b0;
    end else if (!cmd_done_r) begin
      cmd_r      <= {bidir_data_line_in, cmd_r[7:1]};
      cnt_r      <= cnt_r + 3'h1;
      cmd_done_r <= (cnt_r == BIT_LAST);
    end else if (wr_phase) begin
      sh_r   <= sh_nxt;
      wbit_r <= wbit_r + 3'h1;
      if (byte_end) begin
        wbyte_r <= wbyte_r + 3'h1;
        wdone_r <= ~is_burst | (wbyte_r == ADDR_LAST);
      end
    end
  end

  // Handoff words hold steady between bytes, so only the toggle is synchronised
  always_ff @(posedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      wr_tgl_r   <= 1'b0;
      wr_addr_r  <= 3'h0;
      wr_data_r  <= 8'h00;
      wr_burst_r <= 1'b0;
    end else if (byte_end) begin
      wr_tgl_r   <= ~wr_tgl_r;
      wr_addr_r  <= waddr;
      wr_data_r  <= sh_nxt;
      wr_burst_r <= is_burst;
    end
  end

  // ************************************
  // Falling edge: read data out
  // ************************************
  always_ff @(negedge shift_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      oe_r    <= 1'b0;
      dout_r  <= 1'b0;
      rbit_r  <= 3'h0;
      rbyte_r <= 3'h0;
      rdone_r <= 1'b0;
    end else if (rd_phase) begin
      oe_r   <= 1'b1;
      dout_r <= rd_byte[rbit_r];
      rbit_r <= rbit_r + 3'h1;
      if (rbit_r == BIT_LAST && is_burst) begin
        rbyte_r <= rbyte_r + 3'h1;
        rdone_r <= (rbyte_r == ADDR_LAST);
      end
    end else if (rdone_r) begin
      oe_r <= 1'b0;
    end
  end

  assign bidir_data_line_out = dout_r;
  assign bidir_data_line_oe  = oe_r;

  // ************************************
  // Synchronisers (mclk)
  // ************************************
  // Enable only freezes the read snapshot
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      te_s1_r <= 1'b0;
      te_s2_r <= 1'b0;
    end else begin
      te_s1_r <= transfer_enable_line;
      te_s2_r <= te_s1_r;
    end
  end

  // Third stage feeds the crystal edge detector
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      xi_s1_r <= 1'b0;
      xi_s2_r <= 1'b0;
      xi_s3_r <= 1'b0;
    end else begin
      xi_s1_r <= crystal_in_pin;
      xi_s2_r <= xi_s1_r;
      xi_s3_r <= xi_s2_r;
    end
  end

  // Third stage feeds the write event detector
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wt_s1_r <= 1'b0;
      wt_s2_r <= 1'b0;
      wt_s3_r <= 1'b0;
    end else begin
      wt_s1_r <= wr_tgl_r;
      wt_s2_r <= wt_s1_r;
      wt_s3_r <= wt_s2_r;
    end
  end

  // ************************************
  // Write acceptance
  // ************************************
  logic wr_ev;
  logic wr_to_guard;
  logic wr_ok;
  logic halted;
  logic guarded;

  assign halted      = cal_r[ADDR_SEC][HALT_BIT];
  assign guarded     = cal_r[ADDR_GUARD][GUARD_BIT];
  assign wr_ev       = wt_s2_r ^ wt_s3_r;
  assign wr_to_guard = (wr_addr_r == ADDR_GUARD);
  assign wr_ok       = wr_ev & (wr_to_guard ? ~wr_burst_r : ~guarded);

  // ************************************
  // Prescaler: crystal periods to seconds
  // ************************************
  logic xi_rise;
  logic presc_end;
  logic sec_tick;
  logic sec_wr;

  assign xi_rise   = xi_s2_r & ~xi_s3_r;
  assign presc_end = (presc_r == PRESC_W'(OSC_CYCLES_PER_SEC - 1));
  assign sec_tick  = ~halted & xi_rise & presc_end;
  assign sec_wr    = wr_ok & (wr_addr_r == ADDR_SEC);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      presc_r <= '0;
    end else if (halted || sec_wr) begin
      presc_r <= '0;
    end else if (xi_rise) begin
      presc_r <= presc_end ? '0 : presc_r + PRESC_W'(1);
    end
  end

  // Crystal drive stops in standby
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      osc_out_r <= 1'b0;
    end else begin
      osc_out_r <= ~halted & ~xi_s2_r;
    end
  end

  assign crystal_out_pin = osc_out_r;

  // ************************************
  // BCD carry chain
  // ************************************
  logic       mode12;
  logic       pm;
  logic [4:0] h12;
  logic [5:0] h24;
  logic [7:0] sec_inc;
  logic [7:0] min_inc;
  logic [7:0] hr_inc;
  logic [7:0] date_inc;
  logic [7:0] mon_inc;
  logic [7:0] yr_inc;
  logic [7:0] hr_next;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hr_wrap;
  logic       date_wrap;
  logic       mon_wrap;

  assign mode12    = cal_r[ADDR_HOUR][MODE12_BIT];
  assign pm        = cal_r[ADDR_HOUR][PM_BIT];
  assign h12       = cal_r[ADDR_HOUR][4:0];
  assign h24       = cal_r[ADDR_HOUR][5:0];
  assign sec_inc   = twc_bcd_inc({1'b0, cal_r[ADDR_SEC][6:0]});
  assign min_inc   = twc_bcd_inc({1'b0, cal_r[ADDR_MIN][6:0]});
  assign hr_inc    = twc_bcd_inc(mode12 ? {3'h0, h12} : {2'h0, h24});
  assign date_inc  = twc_bcd_inc(cal_r[ADDR_DATE]);
  assign mon_inc   = twc_bcd_inc(cal_r[ADDR_MONTH]);
  assign yr_inc    = twc_bcd_inc(cal_r[ADDR_YEAR]);
  assign sec_wrap  = (cal_r[ADDR_SEC][6:0] == SEC_LAST);
  assign min_wrap  = (cal_r[ADDR_MIN][6:0] == MIN_LAST);
  assign hr_wrap   = mode12 ? (h12 == HR12_PRE && pm) : (h24 == HR24_LAST);
  assign date_wrap = (cal_r[ADDR_DATE] ==
                      twc_month_len(cal_r[ADDR_MONTH], cal_r[ADDR_YEAR]));
  assign mon_wrap  = (cal_r[ADDR_MONTH] == MON_LAST);

  // 11 rolls to 12 with the PM flag flipped, 12 rolls to 01
  assign hr_next = !mode12 ? (h24 == HR24_LAST ? 8'h00 : {2'h0, hr_inc[5:0]})
                 : (h12 == HR12_LAST) ? {2'h2, pm, HR12_FIRST}
                 : (h12 == HR12_PRE)  ? {2'h2, ~pm, HR12_LAST}
                 : {2'h2, pm, hr_inc[4:0]};

  always_comb begin
    cal_nxt = cal_r;
    if (sec_tick) begin
      cal_nxt[ADDR_SEC] = {1'b0, sec_wrap ? 7'h00 : sec_inc[6:0]};
      if (sec_wrap) begin
        cal_nxt[ADDR_MIN] = {1'b0, min_wrap ? 7'h00 : min_inc[6:0]};
        if (min_wrap) begin
          cal_nxt[ADDR_HOUR] = hr_next;
          if (hr_wrap) begin
            cal_nxt[ADDR_DATE] = date_wrap ? BCD_ONE : date_inc;
            cal_nxt[ADDR_WDAY] = (cal_r[ADDR_WDAY][2:0] == WDAY_LAST) ? BCD_ONE
                               : {5'h00, cal_r[ADDR_WDAY][2:0] + 3'h1};
            if (date_wrap) begin
              cal_nxt[ADDR_MONTH] = mon_wrap ? BCD_ONE : mon_inc;
              if (mon_wrap) begin
                cal_nxt[ADDR_YEAR] = (cal_r[ADDR_YEAR] == YEAR_LAST) ? 8'h00 : yr_inc;
              end
            end
          end
        end
      end
    end
    // A host write replaces the register even in a tick cycle
    if (wr_ok) begin
      cal_nxt[wr_addr_r] = wr_data_r & FIELD_MASK[{wr_addr_r, 3'h0} +: 8];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cal_r[i] <= RESET_IMAGE[i*8 +: 8];
      end
    end else begin
      cal_r <= cal_nxt;
    end
  end

  // Snapshot follows the registers while idle and freezes during a transfer
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        snap_r[i] <= RESET_IMAGE[i*8 +: 8];
      end
    end else if (!te_s2_r) begin
      snap_r <= cal_r;
    end
  end

endmodule

// ===== tb/twc_calendar_props.sv
// Link and crystal assertions for the three-wire calendar
`timescale 1ns/10ps
module twc_calendar_props #(
  parameter int OSC_CYCLES_PER_SEC = 4
) (
  // System
  input wire logic mclk,
  input wire logic resetn,
  // Serial link
  input wire logic shift_clk,
  input wire logic transfer_enable_line,
  input wire logic bidir_data_line_in,
  input wire logic bidir_data_line_out,
  input wire logic bidir_data_line_oe,
  // Crystal
  input wire logic crystal_in_pin,
  input wire logic crystal_out_pin
);
  import twc_pkg::*;
  // ********************
  // Edge count and command capture
  // ********************
  logic [6:0] cnt_r;
  logic [7:0] cmd_r;
  wire        sgl_rd;
  wire        bst_rd;
  wire        cmd_ok;
  assign sgl_rd = (cmd_r[7:4] == CMD_SINGLE_HI) && cmd_r[0];
  assign bst_rd = (cmd_r[7:1] == CMD_BURST_HI) && cmd_r[0];
  assign cmd_ok = (cmd_r[7:4] == CMD_SINGLE_HI) || (cmd_r[7:1] == CMD_BURST_HI);
  always_ff @(posedge shift_clk or negedge transfer_enable_line) begin
    if (!transfer_enable_line) begin
      cnt_r <= 7'h0;
      cmd_r <= 8'h0;
    end else begin
      if (cnt_r != 7'h7f) cnt_r <= cnt_r + 7'h1;
      if (cnt_r < 7'h8) cmd_r <= {bidir_data_line_in, cmd_r[7:1]};
    end
  end
  // ********************
  // Properties
  // ********************
  a_cmd_quiet: assert property (@(posedge shift_clk)
    disable iff (!resetn || !transfer_enable_line) cnt_r < 7'h8 |-> !bidir_data_line_oe)
    else $error("data line driven during command");
  a_read_start: assert property (@(posedge shift_clk)
    disable iff (!resetn || !transfer_enable_line) cnt_r >= 7'h8 && sgl_rd |-> bidir_data_line_oe)
    else $error("single read not driving");
  a_write_quiet: assert property (@(posedge shift_clk)
    disable iff (!resetn || !transfer_enable_line) cnt_r >= 7'h8 && !cmd_r[0] |-> !bidir_data_line_oe)
    else $error("write transfer drives line");
  a_bad_cmd: assert property (@(posedge shift_clk)
    disable iff (!resetn || !transfer_enable_line) cnt_r >= 7'h8 && !cmd_ok |-> !bidir_data_line_oe)
    else $error("unknown command answered");
  a_burst_drive: assert property (@(posedge shift_clk)
    disable iff (!resetn || !transfer_enable_line)
    cnt_r >= 7'h8 && cnt_r < 7'h48 && bst_rd |-> bidir_data_line_oe)
    else $error("burst read not driving");
  a_read_repeat: assert property (@(posedge shift_clk)
    disable iff (!resetn || !transfer_enable_line)
    cnt_r >= 7'h10 && sgl_rd |-> bidir_data_line_out == $past(bidir_data_line_out, 8))
    else $error("repeated byte differs");
  a_abort_release: assert property (@(posedge mclk)
    disable iff (!resetn) !transfer_enable_line |-> !bidir_data_line_oe)
    else $error("line driven with enable low");
  a_out_steady: assert property (@(posedge mclk)
    disable iff (!resetn) transfer_enable_line && $past(transfer_enable_line) && shift_clk
    && $past(shift_clk) |-> $stable(bidir_data_line_out))
    else $error("read bit moved while shift clock high");
  a_oe_rise_low: assert property (@(posedge mclk)
    disable iff (!resetn) $rose(bidir_data_line_oe) |-> !shift_clk)
    else $error("drive began outside falling edge");
  a_osc_inverse: assert property (@(posedge mclk)
    disable iff (!resetn) crystal_out_pin |-> !$past(crystal_in_pin, 3))
    else $error("crystal drive not inverse of input");
  c_single: cover property (@(posedge shift_clk) cnt_r == 7'h10 && sgl_rd);
  c_burst: cover property (@(posedge shift_clk) cnt_r == 7'h47 && bst_rd);
  c_write: cover property (@(posedge shift_clk) cnt_r == 7'h10 && !cmd_r[0]);
endmodule

// ===== tb/twc_host.sv
// Host model driving the three-wire link
`timescale 1ns/10ps
module twc_host (
  // Serial link
  output logic      shift_clk,
  output logic      transfer_enable_line,
  output logic      bidir_data_line_in,
  input  wire logic bidir_data_line_out,
  input  wire logic bidir_data_line_oe
);
  logic hd;
  // Released line shows a toggling level
  assign bidir_data_line_in = bidir_data_line_oe ? bidir_data_line_out : hd;
  initial begin
    shift_clk = 1'b1;
    transfer_enable_line = 1'b0;
    hd = 1'b0;
  end
  // ********************
  // Command then n data bits, LSB first; never a test pattern
  // ********************
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [63:0] wd,
                      output logic [63:0] rd);
    logic [71:0] sh;
    sh = {wd, cmd};
    rd = '0;
    transfer_enable_line = 1'b1;
    #200;
    for (int i = 0; i < n + 8; i++) begin
      shift_clk = 1'b0;
      #40;
      if (i < 8 || !cmd[0]) hd = sh[i];
      else hd = ~hd;
      #40;
      shift_clk = 1'b1;
      if (i >= 8) rd[i-8] = bidir_data_line_in;
      #80;
    end
    transfer_enable_line = 1'b0;
    hd = ~hd;
    #400;
  endtask
endmodule

// ===== tb/three_wire_bcd_calendar_tb.sv
// Self-checking bench for the three-wire calendar
`timescale 1ns/10ps
module three_wire_bcd_calendar_tb;
  import twc_pkg::*;
  localparam int OSC = 4;
  localparam logic [63:0] WIMG [2] = '{64'h8023070228b15959, 64'h8024030228235959};
  localparam logic [63:0] EIMG [2] = '{64'h0023010301920000, 64'h0024040229000000};
  logic        mclk;
  logic        resetn;
  logic        crystal_in_pin;
  wire         shift_clk;
  wire         transfer_enable_line;
  wire         bidir_data_line_in;
  wire         bidir_data_line_out;
  wire         bidir_data_line_oe;
  wire         crystal_out_pin;
  logic [63:0] rd;
  int          num_errors;
  int          checked;
  twc_calendar #(.OSC_CYCLES_PER_SEC(OSC)) DUT (.mclk, .resetn, .shift_clk,
    .transfer_enable_line, .bidir_data_line_in, .bidir_data_line_out, .bidir_data_line_oe,
    .crystal_in_pin, .crystal_out_pin);
  twc_host host (.shift_clk, .transfer_enable_line, .bidir_data_line_in,
    .bidir_data_line_out, .bidir_data_line_oe);
  always #25 mclk = ~mclk;
  always #10000 crystal_in_pin = ~crystal_in_pin;
  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    host.xfer({4'h8, a, 1'b1}, 8, 64'h0, rd);
    chk(rd[7:0], e);
  endtask
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end
  // ********************
  // Sequence
  // ********************
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    crystal_in_pin = 1'b0;
    num_errors = 0;
    checked = 0;
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    for (int a = 0; a < NUM_REGS; a++) rreg(a[2:0], RESET_IMAGE[a*8+:8]);
    tend("reset image");
    host.xfer(8'h82, 8, 64'h12, rd);
    rreg(ADDR_MIN, 8'h00);
    host.xfer(8'h8e, 8, 64'h00, rd);
    host.xfer(8'h82, 16, 64'h3345, rd);
    rreg(ADDR_MIN, 8'h45);
    host.xfer(8'h83, 16, 64'h0, rd);
    chk(rd[15:0], 16'h4545);
    host.xfer(8'h82, 4, 64'ha, rd);
    rreg(ADDR_MIN, 8'h45);
    host.xfer(8'h83, 3, 64'h0, rd);
    host.xfer(8'h01, 8, 64'h0, rd);
    host.xfer(8'h80, 8, 64'h00, rd);
    #250000;
    rreg(ADDR_SEC, 8'h03);
    tend("single");
    for (int c = 0; c < 2; c++) begin
      host.xfer(8'hbe, 64, WIMG[c], rd);
      #100000;
      host.xfer(8'hbf, 64, 64'h0, rd);
      chk(rd, EIMG[c]);
    end
    tend("burst");
    host.xfer(8'h80, 8, 64'h80, rd);
    repeat (8) begin
      #25000;
      chk(crystal_out_pin, 1'b0);
    end
    rreg(ADDR_SEC, 8'h80);
    tend("halt");
    test_done();
  end
endmodule
bind twc_calendar twc_calendar_props #(.OSC_CYCLES_PER_SEC(OSC_CYCLES_PER_SEC)) u_props (
  .mclk, .resetn, .shift_clk, .transfer_enable_line, .bidir_data_line_in,
  .bidir_data_line_out, .bidir_data_line_oe, .crystal_in_pin, .crystal_out_pin);
